// [lfcd_defines.svh]
// Offsets, field positions, reset values and counts of the coefficient decoder
`ifndef LFCD_DEFINES_SVH
`define LFCD_DEFINES_SVH

`define LFCD_OFF_ALPHA_MANT 8'h00
`define LFCD_OFF_ALPHA_EXP  8'h04
`define LFCD_OFF_BETA       8'h08
`define LFCD_OFF_GAMMA      8'h0C
`define LFCD_OFF_DELTA      8'h10
`define LFCD_OFF_DIV_INT    8'h14
`define LFCD_OFF_DIV_FRAC   8'h18
`define LFCD_OFF_CTRL       8'h1C
`define LFCD_OFF_STATUS     8'h20
`define LFCD_OFF_RATIO_INT  8'h24
`define LFCD_OFF_RATIO_FRAC 8'h28

`define LFCD_POS_A_SHIFT 0
`define LFCD_POS_A_FRONT 8
`define LFCD_POS_A_BACK  16
`define LFCD_POS_BG_SHIFT 17
`define LFCD_POS_D_SHIFT 15
`define LFCD_POS_DEN 16

`define LFCD_RST_MANT 17'h00001
`define LFCD_RST_SHIFT 6'h00
`define LFCD_RST_DIV_INT 20'h00000
`define LFCD_RST_NUM 10'h000
`define LFCD_RST_DEN 10'h001

`define LFCD_A_BASE 8'h10
`define LFCD_BG_BASE 8'h11
`define LFCD_D_BASE 8'h0F
`define LFCD_GAIN_MAX 6'h16
`define LFCD_OUT_FRAC 32
`define LFCD_QUO_BITS 26
`define LFCD_FRAC_BITS 16

`endif

// [lfcd_pkg.sv]
// Types shared by the coefficient decoder modules
package lfcd_pkg;
  typedef enum logic [1:0] {
    DV_IDLE = 2'b01,
    DV_RUN  = 2'b10
  } lfcd_dv_state_type;

  typedef logic signed [7:0] lfcd_rsh_type;
  typedef logic [16:0] lfcd_mant_type;
  typedef logic signed [63:0] lfcd_term_type;
endpackage : lfcd_pkg

// [lfcd_ratio_if.sv]
// Request and answer signals between the register file and the ratio divider
`timescale 1ns/100ps
interface lfcd_ratio_if;
  logic        start;
  logic [9:0]  num;
  logic [9:0]  den;
  logic        busy;
  logic        done;
  logic        den_zero;
  logic [25:0] quo;

  modport ctl (output start, output num, output den,
               input busy, input done, input den_zero, input quo);
  modport div (input start, input num, input den,
               output busy, output done, output den_zero, output quo);
endinterface : lfcd_ratio_if

// [lfcd_coef_mul.sv]
// One coefficient: mantissa multiply, signed shift, optional negation
`timescale 1ns/100ps
`include "lfcd_defines.svh"
module lfcd_coef_mul
  import lfcd_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          in_vld,
  input  wire logic [31:0]   smp,
  input  wire lfcd_mant_type mant,
  input  wire lfcd_rsh_type  rsh,
  input  wire logic          neg,
  output logic               out_vld,
  output lfcd_term_type      term
);
  logic signed [49:0]  prod;
  logic signed [127:0] wide;
  logic signed [127:0] shifted;
  logic signed [127:0] res;
  lfcd_rsh_type        lsh;

  // Full product kept; bits drop below the output's fraction and above bit 63
  assign prod = $signed(smp) * $signed({1'b0, mant}); // R8
  assign wide = {{78{prod[49]}}, prod} <<< `LFCD_OUT_FRAC;
  assign lsh  = -rsh;

  always_comb begin
    if (rsh[7]) begin
      shifted = wide <<< lsh; // R1
    end else begin
      shifted = wide >>> rsh; // R8
    end
    res = neg ? -shifted : shifted; // R3
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_vld <= 1'b0;
    end else if (ce) begin
      out_vld <= in_vld;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      term <= '0;
    end else if (ce && in_vld) begin
      term <= res[63:0];
    end
  end
endmodule : lfcd_coef_mul

// [lfcd_ratio_div.sv]
// Sequential divider forming the fractional part of the feedback ratio
`timescale 1ns/100ps
`include "lfcd_defines.svh"
module lfcd_ratio_div
  import lfcd_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  ce,
  lfcd_ratio_if.div  rq
);
  lfcd_dv_state_type state_ff;
  logic [25:0]       dvd_ff;
  logic [9:0]        rem_ff;
  logic [4:0]        cnt_ff;
  logic              done_ff;
  logic              dz_ff;
  logic [10:0]       trial;
  logic              qbit;

  assign trial = {rem_ff, dvd_ff[25]};
  assign qbit  = (trial >= {1'b0, rq.den});

  // Restoring division of num * 2^16 by den, one quotient bit a cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= DV_IDLE;
      dvd_ff   <= '0;
      rem_ff   <= '0;
      cnt_ff   <= '0;
    end else if (ce) begin
      case (state_ff)
        DV_IDLE: begin
          if (rq.start && rq.den != 10'h000) begin
            dvd_ff   <= {rq.num, 16'h0000};
            rem_ff   <= '0;
            cnt_ff   <= 5'(`LFCD_QUO_BITS);
            state_ff <= DV_RUN;
          end else if (rq.start) begin
            dvd_ff <= '0;
          end
        end
        DV_RUN: begin
          rem_ff <= qbit ? 10'(trial - {1'b0, rq.den}) : trial[9:0];
          dvd_ff <= {dvd_ff[24:0], qbit};
          cnt_ff <= cnt_ff - 5'h01;
          if (cnt_ff == 5'h01) begin
            state_ff <= DV_IDLE;
          end
        end
        default: state_ff <= DV_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      dz_ff   <= 1'b0;
    end else if (ce) begin
      done_ff <= (state_ff == DV_RUN && cnt_ff == 5'h01) ||
                 (state_ff == DV_IDLE && rq.start && rq.den == 10'h000);
      if (state_ff == DV_IDLE && rq.start) begin
        dz_ff <= (rq.den == 10'h000);
      end
    end
  end

  assign rq.busy     = (state_ff == DV_RUN);
  assign rq.done     = done_ff;
  assign rq.den_zero = dz_ff;
  assign rq.quo      = dvd_ff;
endmodule : lfcd_ratio_div

// [lfcd_top.sv]
// Loop filter coefficient decoder: registers, four coefficient paths, ratio
// Functional notes
// R1: Proportional term is 16-bit mantissa times 2^(-16 - shift + front + back)
// R2: Software fills front gain first up to 7, back gain to total 22
// R3: Second and third coefficients are stored positive and negated inside
// R4: Second coefficient is 17-bit mantissa times 2^-(17 + shift 0..31)
// R5: Third coefficient uses the same format as the second
// R6: Fourth coefficient is 15-bit mantissa times 2^-(15 + shift 0..31)
// R7: Divide ratio is stored integer plus one plus numerator over denominator
// R8: Each coefficient applied as full multiply then arithmetic shift
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "lfcd_defines.svh"
module lfcd_top
  import lfcd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] smp_in,
  input  wire logic        smp_vld,
  output logic      [63:0] prop_term,
  output logic      [63:0] int1_term,
  output logic      [63:0] int2_term,
  output logic      [63:0] aux_term,
  output logic             term_vld,
  output logic      [37:0] div_ratio,
  output logic             ratio_busy
);
  logic [15:0] a_mant_ff;
  logic [5:0]  a_shift_ff;
  logic [2:0]  a_front_ff;
  logic [4:0]  a_back_ff;
  logic [16:0] b_mant_ff;
  logic [4:0]  b_shift_ff;
  logic [16:0] g_mant_ff;
  logic [4:0]  g_shift_ff;
  logic [14:0] d_mant_ff;
  logic [4:0]  d_shift_ff;
  logic [19:0] div_int_ff;
  logic [9:0]  div_num_ff;
  logic [9:0]  div_den_ff;
  logic        run_ff;
  logic        start_ff;
  logic [37:0] ratio_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [5:0]  gain_sum;
  logic        gain_err;
  logic [20:0] int_plus_one;

  lfcd_mant_type mant_arr [4];
  lfcd_rsh_type  rsh_arr  [4];
  logic          neg_arr  [4];
  logic          vld_arr  [4];
  lfcd_term_type term_arr [4];

  lfcd_ratio_if rq ();

  // Single decode helper shared by the write and read paths
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Proportional gain fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_mant_ff  <= 16'(`LFCD_RST_MANT);
      a_shift_ff <= `LFCD_RST_SHIFT;
      a_front_ff <= 3'(`LFCD_RST_SHIFT);
      a_back_ff  <= 5'(`LFCD_RST_SHIFT);
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, `LFCD_OFF_ALPHA_MANT)) begin
        a_mant_ff <= reg_wdata[15:0];
      end else if (hit(reg_addr, `LFCD_OFF_ALPHA_EXP)) begin
        a_shift_ff <= reg_wdata[`LFCD_POS_A_SHIFT +: 6];
        a_front_ff <= reg_wdata[`LFCD_POS_A_FRONT +: 3];
        a_back_ff  <= reg_wdata[`LFCD_POS_A_BACK +: 5];
      end
    end
  end

  // Integrating and damping coefficient fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      b_mant_ff  <= `LFCD_RST_MANT;
      b_shift_ff <= 5'(`LFCD_RST_SHIFT);
      g_mant_ff  <= `LFCD_RST_MANT;
      g_shift_ff <= 5'(`LFCD_RST_SHIFT);
      d_mant_ff  <= 15'(`LFCD_RST_MANT);
      d_shift_ff <= 5'(`LFCD_RST_SHIFT);
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, `LFCD_OFF_BETA)) begin
        b_mant_ff  <= reg_wdata[16:0];
        b_shift_ff <= reg_wdata[`LFCD_POS_BG_SHIFT +: 5];
      end else if (hit(reg_addr, `LFCD_OFF_GAMMA)) begin
        g_mant_ff  <= reg_wdata[16:0];
        g_shift_ff <= reg_wdata[`LFCD_POS_BG_SHIFT +: 5];
      end else if (hit(reg_addr, `LFCD_OFF_DELTA)) begin
        d_mant_ff  <= reg_wdata[14:0];
        d_shift_ff <= reg_wdata[`LFCD_POS_D_SHIFT +: 5];
      end
    end
  end

  // Feedback divider fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_int_ff <= `LFCD_RST_DIV_INT;
      div_num_ff <= `LFCD_RST_NUM;
      div_den_ff <= `LFCD_RST_DEN;
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, `LFCD_OFF_DIV_INT)) begin
        div_int_ff <= reg_wdata[19:0];
      end else if (hit(reg_addr, `LFCD_OFF_DIV_FRAC)) begin
        div_num_ff <= reg_wdata[9:0];
        div_den_ff <= reg_wdata[`LFCD_POS_DEN +: 10];
      end
    end
  end

  // Control: run enable and ratio recompute request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_ff   <= 1'b0;
      start_ff <= 1'b0;
    end else if (ce) begin
      start_ff <= 1'b0;
      if (reg_wr && hit(reg_addr, `LFCD_OFF_CTRL)) begin
        run_ff   <= reg_wdata[0];
        start_ff <= reg_wdata[1];
      end else if (reg_wr && hit(reg_addr, `LFCD_OFF_DIV_FRAC)) begin
        start_ff <= 1'b1;
      end
    end
  end

  // Total proportional gain beyond the field limit is flagged, not clipped
  assign gain_sum = {3'b000, a_front_ff} + {1'b0, a_back_ff};
  assign gain_err = (gain_sum > `LFCD_GAIN_MAX); // R2

  // Net right shifts of each path; negative means a left shift
  assign rsh_arr[0] = `LFCD_A_BASE + {2'b00, a_shift_ff}
                      - {5'b00000, a_front_ff}
                      - {3'b000, a_back_ff}; // R1
  assign rsh_arr[1] = `LFCD_BG_BASE + {3'b000, b_shift_ff}; // R4
  assign rsh_arr[2] = `LFCD_BG_BASE + {3'b000, g_shift_ff}; // R5
  assign rsh_arr[3] = `LFCD_D_BASE + {3'b000, d_shift_ff}; // R6

  assign mant_arr[0] = {1'b0, a_mant_ff}; // R1
  assign mant_arr[1] = b_mant_ff; // R4
  assign mant_arr[2] = g_mant_ff; // R5
  assign mant_arr[3] = {2'b00, d_mant_ff}; // R6

  // Stored magnitudes of the two integrating paths turn negative here
  assign neg_arr[0] = 1'b0;
  assign neg_arr[1] = 1'b1; // R3
  assign neg_arr[2] = 1'b1; // R3
  assign neg_arr[3] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_coef
      lfcd_coef_mul u_mul (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .in_vld  (smp_vld && run_ff),
        .smp     (smp_in),
        .mant    (mant_arr[gi]),
        .rsh     (rsh_arr[gi]),
        .neg     (neg_arr[gi]),
        .out_vld (vld_arr[gi]),
        .term    (term_arr[gi])
      );
    end
  endgenerate

  assign prop_term = term_arr[0];
  assign int1_term = term_arr[1];
  assign int2_term = term_arr[2];
  assign aux_term  = term_arr[3];
  assign term_vld  = vld_arr[0];

  // Ratio divider
  assign rq.start = start_ff;
  assign rq.num   = div_num_ff;
  assign rq.den   = div_den_ff;

  lfcd_ratio_div u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .rq      (rq)
  );

  assign int_plus_one = {1'b0, div_int_ff} + 21'h000001; // R7

  // Ratio holds its last value until the divider finishes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ratio_ff <= '0;
    end else if (ce && rq.done) begin
      ratio_ff <= {1'b0, int_plus_one, 16'h0000}
                  + {12'h000, rq.quo}; // R7
    end
  end

  assign div_ratio  = ratio_ff;
  assign ratio_busy = rq.busy || start_ff;

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit(reg_addr, `LFCD_OFF_ALPHA_MANT)) begin
      nxt_rdata = {16'h0000, a_mant_ff};
    end else if (hit(reg_addr, `LFCD_OFF_ALPHA_EXP)) begin
      nxt_rdata = {11'h000, a_back_ff, 5'h00, a_front_ff,
                   2'b00, a_shift_ff};
    end else if (hit(reg_addr, `LFCD_OFF_BETA)) begin
      nxt_rdata = {10'h000, b_shift_ff, b_mant_ff};
    end else if (hit(reg_addr, `LFCD_OFF_GAMMA)) begin
      nxt_rdata = {10'h000, g_shift_ff, g_mant_ff};
    end else if (hit(reg_addr, `LFCD_OFF_DELTA)) begin
      nxt_rdata = {12'h000, d_shift_ff, d_mant_ff};
    end else if (hit(reg_addr, `LFCD_OFF_DIV_INT)) begin
      nxt_rdata = {12'h000, div_int_ff};
    end else if (hit(reg_addr, `LFCD_OFF_DIV_FRAC)) begin
      nxt_rdata = {6'h00, div_den_ff, 6'h00, div_num_ff};
    end else if (hit(reg_addr, `LFCD_OFF_CTRL)) begin
      nxt_rdata = {31'h00000000, run_ff};
    end else if (hit(reg_addr, `LFCD_OFF_STATUS)) begin
      nxt_rdata = {29'h00000000, rq.den_zero, gain_err, ratio_busy};
    end else if (hit(reg_addr, `LFCD_OFF_RATIO_INT)) begin
      nxt_rdata = {10'h000, ratio_ff[37:16]};
    end else if (hit(reg_addr, `LFCD_OFF_RATIO_FRAC)) begin
      nxt_rdata = {16'h0000, ratio_ff[15:0]};
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule : lfcd_top

// [lfcd_chk.sv]
// Port-level assertions for the coefficient decoder
`timescale 1ns/100ps
module lfcd_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] smp_in,
  input wire logic        smp_vld,
  input wire logic [63:0] prop_term,
  input wire logic [63:0] int1_term,
  input wire logic [63:0] int2_term,
  input wire logic [63:0] aux_term,
  input wire logic        term_vld,
  input wire logic [37:0] div_ratio,
  input wire logic        ratio_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Prop term is left out here: its gain may legally wrap the sign bit
  sequence s_pos;
    term_vld && !$past(smp_in[31]) && $past(smp_in) != 32'h0;
  endsequence
  sequence s_zero;
    term_vld && $past(smp_in) == 32'h0;
  endsequence

  a_rdata_idle:
    assert property (ce && $past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_vld_cause:
    assert property (term_vld |-> ($past(ce) ? $past(smp_vld)
                                             : $past(term_vld)))
    else $error("term valid without an accepted sample");
  a_terms_hold:
    assert property (!term_vld |-> $stable(prop_term) && $stable(int1_term)
                     && $stable(int2_term) && $stable(aux_term))
    else $error("terms moved without a sample");
  a_int1_neg:
    assert property (s_pos |-> int1_term[63] || int1_term == 64'h0)
    else $error("second term not negated");
  a_int2_neg:
    assert property (s_pos |-> int2_term[63] || int2_term == 64'h0)
    else $error("third term not negated");
  a_aux_pos:
    assert property (s_pos |-> !aux_term[63])
    else $error("fourth term negative");
  a_zero_in:
    assert property (s_zero |-> prop_term == 64'h0 && int1_term == 64'h0
                     && int2_term == 64'h0 && aux_term == 64'h0)
    else $error("zero sample gave nonzero term");
  a_busy_bound:
    assert property ($rose(ratio_busy) |-> ##[1:40] !ratio_busy)
    else $error("ratio recompute too long");
  a_ratio_moves:
    assert property ($changed(div_ratio)
                     |-> $past(ratio_busy) || $past(ratio_busy, 2))
    else $error("ratio changed without recompute");
endmodule : lfcd_chk

bind lfcd_top lfcd_chk u_lfcd_chk (
  .ref_clk    (ref_clk),
  .rst        (rst),
  .ce         (ce),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .smp_in     (smp_in),
  .smp_vld    (smp_vld),
  .prop_term  (prop_term),
  .int1_term  (int1_term),
  .int2_term  (int2_term),
  .aux_term   (aux_term),
  .term_vld   (term_vld),
  .div_ratio  (div_ratio),
  .ratio_busy (ratio_busy)
);

// [testbench.sv]
// Self-checking bench for the coefficient decoder
`timescale 1ns/100ps
`include "lfcd_defines.svh"
module testbench
  import lfcd_pkg::*;
();
  logic        ref_clk, rst, ce, reg_wr, reg_rd, smp_vld, term_vld, ratio_busy;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, smp_in;
  logic [63:0] prop_term, int1_term, int2_term, aux_term;
  logic [37:0] div_ratio;
  int          err_total;
  int          comparisons;

  lfcd_top u_lfcd_top (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .smp_in(smp_in), .smp_vld(smp_vld),
    .prop_term(prop_term), .int1_term(int1_term), .int2_term(int2_term),
    .aux_term(aux_term), .term_vld(term_vld), .div_ratio(div_ratio),
    .ratio_busy(ratio_busy));

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand one cycle only, so they are taken right after the edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, want);
  endtask : rdc

  function automatic lfcd_term_type scale(input logic [31:0] s, input int m,
                                          input int e);
    lfcd_term_type p;
    p = $signed(s) * m;
    return (e >= 0) ? (p <<< e) : (p >>> -e);
  endfunction : scale

  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(prop_term | int1_term | int2_term | aux_term, 64'h0);
    chk({term_vld, ratio_busy, div_ratio}, 64'h0);
    rdc(`LFCD_OFF_ALPHA_MANT, 32'h00000001);
    rdc(`LFCD_OFF_BETA, 32'h00000001);
    rdc(`LFCD_OFF_DIV_FRAC, 32'h00010000);
    rdc(8'h2C, 32'h00000000);
  endtask : t_reset

  // Samples are multiples of 2^16 so every expected term is exact
  task automatic t_coef(input int am, a1, a2, a3, bm, b1, gm, g1, dm, d1,
                        input logic [31:0] s);
    lfcd_term_type held;
    wr(`LFCD_OFF_ALPHA_MANT, am);
    wr(`LFCD_OFF_ALPHA_EXP, a1 | (a2 << 8) | (a3 << 16));
    wr(`LFCD_OFF_BETA, bm | (b1 << 17));
    wr(`LFCD_OFF_GAMMA, gm | (g1 << 17));
    wr(`LFCD_OFF_DELTA, dm | (d1 << 15));
    wr(`LFCD_OFF_CTRL, 32'h00000001);
    rdc(`LFCD_OFF_ALPHA_EXP, a1 | (a2 << 8) | (a3 << 16));
    rdc(`LFCD_OFF_GAMMA, gm | (g1 << 17));
    rdc(`LFCD_OFF_DELTA, dm | (d1 << 15));
    rdc(`LFCD_OFF_STATUS, (a2 + a3 > 22) ? 32'h2 : 32'h0);
    @(posedge ref_clk);
    smp_in  <= s;
    smp_vld <= 1'b1;
    @(posedge ref_clk);
    smp_vld <= 1'b0;
    #1;
    chk(term_vld, 1'b1);
    chk(prop_term, scale(s, am, 16 - a1 + a2 + a3));
    chk(int1_term, -scale(s, bm, 15 - b1));
    chk(int2_term, -scale(s, gm, 15 - g1));
    chk(aux_term, scale(s, dm, 17 - d1));
    held = prop_term;
    @(posedge ref_clk);
    #1;
    chk(term_vld, 1'b0);
    wr(`LFCD_OFF_CTRL, 32'h00000000);
    @(posedge ref_clk);
    smp_vld <= 1'b1;
    @(posedge ref_clk);
    smp_vld <= 1'b0;
    #1;
    chk({term_vld, prop_term}, {1'b0, held});
  endtask : t_coef

  task automatic t_ratio(input int s, u, v, input bit kick);
    longint want;
    want = (longint'(s + 1) << 16) + ((v != 0) ? (longint'(u) << 16) / v : 0);
    wr(`LFCD_OFF_DIV_INT, s);
    if (kick)
      wr(`LFCD_OFF_CTRL, 32'h00000002);
    else
      wr(`LFCD_OFF_DIV_FRAC, u | (v << 16));
    #1;
    for (int i = 0; i < 60 && ratio_busy; i++) begin
      @(posedge ref_clk);
      #1;
    end
    // A recompute that never ends counts against the run
    chk(ratio_busy, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(div_ratio, want[37:0]);
    rdc(`LFCD_OFF_RATIO_INT, want[37:16]);
    rdc(`LFCD_OFF_RATIO_FRAC, want[15:0]);
    rdc(`LFCD_OFF_STATUS, (v == 0) ? 32'h4 : 32'h0);
    rdc(`LFCD_OFF_DIV_INT, s);
  endtask : t_ratio

  // A write with the clock enable low must leave the field alone
  task automatic t_ce_hold;
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(`LFCD_OFF_ALPHA_MANT, 32'h5);
    ce <= 1'b1;
    rdc(`LFCD_OFF_ALPHA_MANT, 32'hFFFF);
  endtask : t_ce_hold

  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    smp_in = 32'h0;
    smp_vld = 1'b0;
    err_total = 0;
    comparisons = 0;
    t_reset();
    t_coef(53416, 6, 0, 0, 75019, 13, 80571, 13, 16906, 8, 32'h00010000);
    t_coef(1, 0, 7, 16, 131071, 31, 1, 0, 32767, 31, 32'h7FFF0000);
    t_coef(3, 0, 7, 15, 1, 0, 131071, 31, 1, 0, 32'hFFFF0000);
    t_coef(65535, 32, 0, 0, 2, 5, 3, 7, 5, 3, 32'h00000000);
    t_ce_hold();
    t_ratio(5, 1, 4, 1'b0);
    t_ratio(20'hFFFFF, 1023, 1023, 1'b0);
    t_ratio(2, 5, 2, 1'b0);
    t_ratio(7, 3, 0, 1'b0);
    t_ratio(9, 3, 0, 1'b1);
    t_reset();
    wrap_up();
  end

  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule : testbench
